// File: common/low_side_pkg.sv
package low_side_pkg;

   // ------------------------------------------------------------------
   // Address map of the die link
   // ------------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] BLOCKING_BASE = 10'h200;
   localparam logic [ADDR_W-1:0] NON_BLOCKING_BASE = 10'h300;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 10'h030;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 10'h031;
   localparam logic [ADDR_W-1:0] KEY_OFFSET = 10'h032;

   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int CTRL_DRV_LSB = 0;
   localparam int CTRL_PULSE_EN_LSB = 2;
   localparam int CTRL_PULSE_SEL_LSB = 4;
   localparam int CTRL_OT_IE_BIT = 7;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hbf;
   localparam logic [3:0] KEY_GRANT = 4'h5;

   // ------------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] KEY_RESET = 4'h0;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } die_link_req_t;

   typedef struct packed {
      logic reg_one_ov;
      logic reg_two_ov;
      logic overtemp;
      logic [1:0] open_load;
      logic [1:0] current_limit;
   } analog_status_t;

endpackage : low_side_pkg

// File: hdl/low_side_driver_control.sv
`timescale 1ns/100ps

module low_side_driver_control (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // Die link register access
   input wire low_side_pkg::die_link_req_t link_req_in,
   output logic [7:0] link_rdata_out,
   // Analog section and pulse channels
   input wire low_side_pkg::analog_status_t analog_in,
   input wire logic [1:0] pulse_ch_in,
   input wire logic normal_mode_in,
   // Voltage status and interrupt controller hooks
   input wire logic regulator_ov_irq_enable_in,
   input wire logic voltage_status_read_in,
   input wire logic low_side_irq_mask_in,
   // Drivers and indications
   output logic [1:0] driver_on_bits_out,
   output logic regulator_overvoltage_cond_out,
   output logic regulator_ov_irq_out,
   output logic overtemp_irq_flag_out,
   output logic low_side_irq_out
);

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [low_side_pkg::ADDR_W-1:0] addr,
                                input logic [low_side_pkg::ADDR_W-1:0] offset);
      hit = (addr == low_side_pkg::BLOCKING_BASE + offset) ||
            (addr == low_side_pkg::NON_BLOCKING_BASE + offset);
   endfunction : hit

   logic wr_ctrl;
   logic wr_key;
   logic rd_ctrl;
   logic rd_status;
   logic rd_key;

   assign wr_ctrl = link_req_in.wr && hit(link_req_in.addr, low_side_pkg::CTRL_OFFSET);
   assign wr_key = link_req_in.wr && hit(link_req_in.addr, low_side_pkg::KEY_OFFSET);
   assign rd_ctrl = link_req_in.rd && hit(link_req_in.addr, low_side_pkg::CTRL_OFFSET);
   assign rd_status = link_req_in.rd && hit(link_req_in.addr, low_side_pkg::STATUS_OFFSET);
   assign rd_key = link_req_in.rd && hit(link_req_in.addr, low_side_pkg::KEY_OFFSET);

   // ------------------------------------------------------------------
   // Analog capture
   // ------------------------------------------------------------------
   low_side_pkg::analog_status_t analog_q;
   logic ov_prev_q;
   logic ot_prev_q;
   logic ov_now;
   logic ov_rise;
   logic ot_rise;

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         analog_q <= '0;
         ov_prev_q <= 1'b0;
         ot_prev_q <= 1'b0;
      end
      else
      begin
         analog_q <= analog_in;
         ov_prev_q <= ov_now;
         ot_prev_q <= analog_q.overtemp;
      end
   end

   assign ov_now = analog_q.reg_one_ov | analog_q.reg_two_ov;
   assign ov_rise = ov_now & ~ov_prev_q;
   assign ot_rise = analog_q.overtemp & ~ot_prev_q;

   // ------------------------------------------------------------------
   // Control, key and shutdown state
   // ------------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [3:0] key_q;
   logic [3:0] key_d;
   logic unlocked_q;
   logic unlocked_d;
   logic ot_shut_q;
   logic ot_shut_d;
   logic [1:0] drv_q;
   logic [1:0] drv_d;

   always_comb
   begin
      ctrl_d = ctrl_q;
      key_d = key_q;
      unlocked_d = unlocked_q;
      ot_shut_d = ot_shut_q;
      if (wr_key)
      begin
         key_d = link_req_in.wdata[3:0];
         unlocked_d = (link_req_in.wdata[3:0] == low_side_pkg::KEY_GRANT);
      end
      if (ov_rise)
      begin
         key_d = low_side_pkg::KEY_RESET;
         unlocked_d = 1'b0;
      end
      if (wr_ctrl)
      begin
         ctrl_d = link_req_in.wdata & low_side_pkg::CTRL_WRITE_MASK;
         // Link writes move the enable bits only while unlocked
         if (!unlocked_q)
            ctrl_d[1:0] = ctrl_q[1:0];
         if (!analog_q.overtemp)
            ot_shut_d = 1'b0;
      end
      if (ov_now)
         ctrl_d[1:0] = 2'b00;
      if (analog_q.overtemp)
         ot_shut_d = 1'b1;
      drv_d = 2'b00;
      for (int i = 0; i < 2; i++)
      begin
         drv_d[i] = ctrl_q[low_side_pkg::CTRL_DRV_LSB + i] && unlocked_q &&
                    (key_q == low_side_pkg::KEY_GRANT) && !ov_now && !ot_shut_q &&
                    normal_mode_in;
         if (ctrl_q[low_side_pkg::CTRL_PULSE_EN_LSB + i])
            drv_d[i] = drv_d[i] &&
                       pulse_ch_in[ctrl_q[low_side_pkg::CTRL_PULSE_SEL_LSB + i]];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_q <= low_side_pkg::CTRL_RESET;
         key_q <= low_side_pkg::KEY_RESET;
         unlocked_q <= 1'b0;
         ot_shut_q <= 1'b0;
         drv_q <= 2'b00;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         key_q <= key_d;
         unlocked_q <= unlocked_d;
         ot_shut_q <= ot_shut_d;
         drv_q <= drv_d;
      end
   end

   assign driver_on_bits_out = drv_q;

   // ------------------------------------------------------------------
   // Status flags and interrupts
   // ------------------------------------------------------------------
   logic [1:0] open_load_q;
   logic [1:0] open_load_d;
   logic [1:0] cur_lim_q;
   logic [1:0] cur_lim_d;
   logic ov_cond_q;
   logic ov_irq_q;
   logic ov_irq_d;
   logic ot_flag_q;
   logic ot_flag_d;
   logic ls_irq_q;
   logic ls_irq_d;

   always_comb
   begin
      open_load_d = analog_q.open_load & drv_q;
      cur_lim_d = analog_q.current_limit;
      ov_irq_d = ov_irq_q;
      if (voltage_status_read_in)
         ov_irq_d = 1'b0;
      if (ov_rise && regulator_ov_irq_enable_in)
         ov_irq_d = 1'b1;
      ot_flag_d = ot_flag_q;
      if (rd_status)
         ot_flag_d = 1'b0;
      if (ot_rise)
         ot_flag_d = 1'b1;
      ls_irq_d = ot_flag_d && low_side_irq_mask_in;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         open_load_q <= 2'b00;
         cur_lim_q <= 2'b00;
         ov_cond_q <= 1'b0;
         ov_irq_q <= 1'b0;
         ot_flag_q <= 1'b0;
         ls_irq_q <= 1'b0;
      end
      else
      begin
         open_load_q <= open_load_d;
         cur_lim_q <= cur_lim_d;
         ov_cond_q <= ov_now;
         ov_irq_q <= ov_irq_d;
         ot_flag_q <= ot_flag_d;
         ls_irq_q <= ls_irq_d;
      end
   end

   assign regulator_overvoltage_cond_out = ov_cond_q;
   assign regulator_ov_irq_out = ov_irq_q;
   assign overtemp_irq_flag_out = ot_flag_q;
   assign low_side_irq_out = ls_irq_q;

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb
   begin
      rdata_d = low_side_pkg::READ_IDLE;
      if (rd_ctrl)
         rdata_d = ctrl_q;
      else if (rd_status)
         rdata_d = {analog_q.overtemp, 3'h0, cur_lim_q, open_load_q};
      else if (rd_key)
         rdata_d = {4'h0, key_q};
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rdata_q <= low_side_pkg::READ_IDLE;
      else
         rdata_q <= rdata_d;
   end

   assign link_rdata_out = rdata_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   a_key_grant_cause: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(unlocked_q) |-> $past(wr_key && link_req_in.wdata[3:0] == 4'h5))
      else $error("unlock without correct key write");

   a_driver_needs_unlock: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      driver_on_bits_out[0] |-> $past(ctrl_q[0] && unlocked_q))
      else $error("driver one on without enable and unlock");

   a_ov_clears_enables: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      ov_now |=> ctrl_q[1:0] == 2'b00 && driver_on_bits_out == 2'b00)
      else $error("enables survive overvoltage");

   a_ov_cond_tracks: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      ##1 regulator_overvoltage_cond_out == $past(ov_now))
      else $error("overvoltage condition bit does not track");

   a_ov_irq_enabled: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(regulator_ov_irq_out) |-> $past(regulator_ov_irq_enable_in))
      else $error("overvoltage interrupt while disabled");

   a_ov_irq_read_clear: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      voltage_status_read_in && !ov_rise |=> !regulator_ov_irq_out)
      else $error("overvoltage interrupt not cleared by read");

   a_ov_no_retrigger: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(regulator_ov_irq_out) |-> $past(ov_now && !ov_prev_q))
      else $error("overvoltage interrupt without fresh event");

   a_open_load_off: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (open_load_q & ~$past(drv_q)) == 2'b00)
      else $error("open load reported for an off driver");

   a_ot_shutdown: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      analog_q.overtemp |=> ##1 driver_on_bits_out == 2'b00)
      else $error("drivers on during overtemperature");

   a_ot_irq_mask: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      low_side_irq_out |-> $past(low_side_irq_mask_in) && overtemp_irq_flag_out)
      else $error("overtemperature interrupt while masked");

   a_sleep_holds_off: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !normal_mode_in |=> driver_on_bits_out == 2'b00)
      else $error("driver on outside normal mode");

   a_ot_flag_clear: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      rd_status && !ot_rise |=> !overtemp_irq_flag_out)
      else $error("status read did not clear overtemperature flag");

endmodule : low_side_driver_control

// File: bench/die_link_host.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Host side of the die link
// ------------------------------------------------------------------
module die_link_host (
   // Clock
   input wire logic core_clk_in,
   // Die link
   output low_side_pkg::die_link_req_t link_req_out,
   input wire logic [7:0] link_rdata_in
);
   initial link_req_out = '0;

   // Released address and data show the inverse of the last value
   task automatic bus_write(input logic [9:0] addr, input logic [7:0] data);
      @(posedge core_clk_in);
      link_req_out <= {1'b1, 1'b0, addr, data};
      @(posedge core_clk_in);
      link_req_out <= {1'b0, 1'b0, ~addr, ~data};
   endtask : bus_write

   task automatic bus_read(input logic [9:0] addr, output logic [7:0] data);
      @(posedge core_clk_in);
      link_req_out <= {1'b0, 1'b1, addr, 8'h00};
      @(posedge core_clk_in);
      link_req_out <= {1'b0, 1'b0, ~addr, 8'hff};
      #1;
      data = link_rdata_in;
   endtask : bus_read

   // Key written once before any enable after reset or overvoltage
   task automatic unlock(input logic [9:0] base);
      bus_write(base + low_side_pkg::KEY_OFFSET, 8'h05);
   endtask : unlock
endmodule : die_link_host

// File: bench/low_side_driver_control_bench.sv
`timescale 1ns/100ps

module low_side_driver_control_bench;
   localparam logic [9:0] BB = low_side_pkg::BLOCKING_BASE;
   localparam logic [9:0] NB = low_side_pkg::NON_BLOCKING_BASE;
   localparam logic [9:0] CTRL = BB + low_side_pkg::CTRL_OFFSET;
   localparam logic [9:0] STAT = BB + low_side_pkg::STATUS_OFFSET;
   localparam logic [9:0] KEY = BB + low_side_pkg::KEY_OFFSET;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   low_side_pkg::die_link_req_t req;
   low_side_pkg::analog_status_t analog = '0;
   logic [7:0] rdata;
   logic [1:0] pulse_ch = 2'b00;
   logic normal_mode = 1'b1;
   logic ov_ie = 1'b0;
   logic vs_read = 1'b0;
   logic ls_mask = 1'b0;
   logic [1:0] drv;
   logic cond, ov_irq, ot_flag, ls_irq;
   int n_errors = 0;
   int n_tests = 0;

   always #10 clk = ~clk;

   low_side_driver_control uut (
      .core_clk_in(clk), .rst_n_in(rst_n), .link_req_in(req), .link_rdata_out(rdata),
      .analog_in(analog), .pulse_ch_in(pulse_ch), .normal_mode_in(normal_mode),
      .regulator_ov_irq_enable_in(ov_ie), .voltage_status_read_in(vs_read),
      .low_side_irq_mask_in(ls_mask), .driver_on_bits_out(drv),
      .regulator_overvoltage_cond_out(cond), .regulator_ov_irq_out(ov_irq),
      .overtemp_irq_flag_out(ot_flag), .low_side_irq_out(ls_irq));

   die_link_host host (.core_clk_in(clk), .link_req_out(req), .link_rdata_in(rdata));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic chk_rd(input logic [9:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      host.bus_read(addr, d);
      n_tests++;
      if (d !== exp)
      begin
         n_errors++;
         $display("Error %0t: read %h gave %h expected %h", $time, addr, d, exp);
      end
   endtask : chk_rd

   task automatic chk_pins(input logic [5:0] exp);
      n_tests++;
      if ({drv, cond, ov_irq, ot_flag, ls_irq} !== exp)
      begin
         n_errors++;
         $display("Error %0t: pins %b expected %b", $time,
            {drv, cond, ov_irq, ot_flag, ls_irq}, exp);
      end
   endtask : chk_pins

   task automatic wr_settle(input logic [9:0] addr, input logic [7:0] data);
      host.bus_write(addr, data);
      settle();
   endtask : wr_settle

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      chk_pins(6'b000000);
      chk_rd(CTRL, 8'h00);
      chk_rd(STAT, 8'h00);
      chk_rd(KEY, 8'h00);
      host.bus_write(STAT, 8'hff);
      chk_rd(STAT, 8'h00);
      chk_rd(BB + 10'h0ff, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_lock();
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b000000);
      chk_rd(CTRL, 8'h00);
      wr_settle(KEY, 8'h03);
      chk_rd(KEY, 8'h03);
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b000000);
      host.unlock(NB);
      chk_rd(KEY, 8'h05);
      wr_settle(NB + low_side_pkg::CTRL_OFFSET, 8'hc3);
      chk_pins(6'b110000);
      chk_rd(CTRL, 8'h83);
      wr_settle(CTRL, 8'h01);
      chk_pins(6'b010000);
      $display("test lock done");
   endtask : t_lock

   task automatic t_status();
      @(posedge clk);
      analog.open_load <= 2'b11;
      analog.current_limit <= 2'b10;
      settle();
      chk_rd(STAT, 8'h09);
      @(posedge clk);
      analog.open_load <= 2'b00;
      analog.current_limit <= 2'b00;
      $display("test status done");
   endtask : t_status

   task automatic t_pulse();
      wr_settle(CTRL, 8'h1f);
      chk_rd(CTRL, 8'h1f);
      @(posedge clk);
      pulse_ch <= 2'b10;
      settle();
      chk_pins(6'b010000);
      @(posedge clk);
      pulse_ch <= 2'b01;
      settle();
      chk_pins(6'b100000);
      $display("test pulse done");
   endtask : t_pulse

   task automatic t_mode();
      wr_settle(CTRL, 8'h03);
      @(posedge clk);
      normal_mode <= 1'b0;
      settle();
      chk_pins(6'b000000);
      @(posedge clk);
      normal_mode <= 1'b1;
      settle();
      chk_pins(6'b110000);
      $display("test mode done");
   endtask : t_mode

   task automatic t_overvoltage();
      @(posedge clk);
      ov_ie <= 1'b1;
      analog.reg_one_ov <= 1'b1;
      settle();
      chk_pins(6'b001100);
      chk_rd(CTRL, 8'h00);
      chk_rd(KEY, 8'h00);
      @(posedge clk);
      vs_read <= 1'b1;
      @(posedge clk);
      vs_read <= 1'b0;
      settle();
      chk_pins(6'b001000);
      @(posedge clk);
      analog.reg_one_ov <= 1'b0;
      settle();
      chk_pins(6'b000000);
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b000000);
      host.unlock(BB);
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b110000);
      @(posedge clk);
      ov_ie <= 1'b0;
      analog.reg_two_ov <= 1'b1;
      settle();
      chk_pins(6'b001000);
      @(posedge clk);
      analog.reg_two_ov <= 1'b0;
      settle();
      $display("test overvoltage done");
   endtask : t_overvoltage

   task automatic t_overtemp();
      host.unlock(BB);
      wr_settle(CTRL, 8'h03);
      @(posedge clk);
      analog.overtemp <= 1'b1;
      settle();
      chk_pins(6'b000010);
      @(posedge clk);
      ls_mask <= 1'b1;
      settle();
      chk_pins(6'b000011);
      @(posedge clk);
      analog.overtemp <= 1'b0;
      settle();
      chk_pins(6'b000011);
      chk_rd(STAT, 8'h00);
      settle();
      chk_pins(6'b000000);
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b110000);
      @(posedge clk);
      analog.overtemp <= 1'b1;
      settle();
      chk_rd(STAT, 8'h80);
      settle();
      chk_pins(6'b000000);
      @(posedge clk);
      analog.overtemp <= 1'b0;
      $display("test overtemp done");
   endtask : t_overtemp

   task automatic t_midreset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk_pins(6'b000000);
      chk_rd(KEY, 8'h00);
      chk_rd(CTRL, 8'h00);
      wr_settle(CTRL, 8'h03);
      chk_pins(6'b000000);
      $display("test reset again done");
   endtask : t_midreset

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_lock();
      t_status();
      t_pulse();
      t_mode();
      t_overvoltage();
      t_overtemp();
      t_midreset();
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("Error %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : low_side_driver_control_bench
